// ---- core/adcu_pkg.sv ----
// Notes on behaviour
// - Trigger enable low: trigger pin ignored, only the software flag starts.
// - Trigger enable high: either edge on the trigger pin starts a conversion.
// - Channel code 00xx none, 0100-0111 inputs 0-3, 1000-1011 inputs 4-7, 11xx reserved.
// - Conversion lasts 62 clocks with period select 0, 31 clocks with it 1.
// - Start flag reads 0 once the conversion has completed.
// - Writing 1 starts, writing 0 stops; flag reads 1 while converting.
package adcu_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_MODE_CFG = 8'hc4;
    localparam logic [7:0] ADDR_RESULT = 8'hc5;
    localparam logic [7:0] ADDR_START = 8'hc6;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc7;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hc8;

    // ****************************************
    // Field positions and fixed bits
    // ****************************************
    localparam int CFG_PERIOD_BIT = 7;
    localparam int CFG_TRIG_BIT = 6;
    localparam int START_FLAG_BIT = 7;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_TRIG_BIT = 1;
    localparam logic [7:0] CFG_FIXED_ONES = 8'h30;
    localparam logic [7:0] START_FIXED_ONES = 8'h7f;
    localparam logic [1:0] CHAN_LOW_GROUP = 2'h1;
    localparam logic [1:0] CHAN_HIGH_GROUP = 2'h2;

    // ****************************************
    // Values after reset and at conversion start
    // ****************************************
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [7:0] SAR_FIRST_BIT = 8'h80;

    // ****************************************
    // Cycle counts
    // ****************************************
    localparam int CONV_CYCLES_SLOW = 62;
    localparam int CONV_CYCLES_FAST = 31;
    localparam logic [5:0] CONV_LAST_SLOW = 6'(CONV_CYCLES_SLOW - 1);
    localparam logic [5:0] CONV_LAST_FAST = 6'(CONV_CYCLES_FAST - 1);
    // Last cycle of each bit trial (7 cycles slow, 3 fast); eight trials fit inside each period
    localparam logic [2:0] TRIAL_LAST_SLOW = 3'h6;
    localparam logic [2:0] TRIAL_LAST_FAST = 3'h2;

    typedef enum logic {
        ADCU_IDLE = 1'b0,
        ADCU_CONV = 1'b1
    } adcu_state_type;

endpackage

// ---- core/adcu_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcu_pin_sync (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic level_out,
    output logic edge_out
);

    // ****************************************
    // Two-stage synchroniser and edge stage
    // ****************************************
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic meta_next;
    logic sync_next;
    logic prev_next;

    // Next values
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // Registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // Either edge after synchronisation
    assign level_out = sync_reg;
    assign edge_out = sync_reg ^ prev_reg;

endmodule
`default_nettype wire

// ---- core/adcu_top.sv ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module adcu_top
    import adcu_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    input wire logic ext_trigger_pin_in,
    input wire logic cmp_in,
    output logic [7:0] dac_code_out,
    output logic [2:0] chan_idx_out,
    output logic chan_en_out,
    output logic conv_busy_out
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic trig_edge;
    logic cmp_level;

    adcu_pin_sync u_trig_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pin_in(ext_trigger_pin_in),
        .level_out(),
        .edge_out(trig_edge)
    );

    adcu_pin_sync u_cmp_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pin_in(cmp_in),
        .level_out(cmp_level),
        .edge_out()
    );

    // ****************************************
    // State
    // ****************************************
    adcu_state_type state_reg;
    adcu_state_type state_next;
    logic conv_period_sel_reg;
    logic conv_period_sel_next;
    logic ext_trigger_enable_reg;
    logic ext_trigger_enable_next;
    logic [3:0] chan_sel_reg;
    logic [3:0] chan_sel_next;
    logic run_fast_reg;
    logic run_fast_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [2:0] step_reg;
    logic [2:0] step_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] sar_reg;
    logic [7:0] sar_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_stat_next;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_mask_next;
    logic irq_reg;
    logic irq_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [2:0] chan_idx_reg;
    logic [2:0] chan_idx_next;
    logic chan_en_reg;
    logic chan_en_next;

    // ****************************************
    // Decode
    // ****************************************
    logic wr_start;
    logic wr_start_one;
    logic wr_start_zero;
    logic trig_start;
    logic done_evt;
    logic [5:0] conv_last;
    logic [2:0] trial_last;

    assign wr_start = wr_in && (addr_in == ADDR_START);
    assign wr_start_one = wr_start && wdata_in[START_FLAG_BIT];
    assign wr_start_zero = wr_start && !wdata_in[START_FLAG_BIT];
    assign trig_start = ext_trigger_enable_reg && trig_edge;
    assign conv_last = run_fast_reg ? CONV_LAST_FAST : CONV_LAST_SLOW;
    assign trial_last = run_fast_reg ? TRIAL_LAST_FAST : TRIAL_LAST_SLOW;

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always_comb begin
        state_next = state_reg;
        run_fast_next = run_fast_reg;
        cnt_next = cnt_reg;
        step_next = step_reg;
        mask_next = mask_reg;
        sar_next = sar_reg;
        result_next = result_reg;
        done_evt = 1'b0;
        case (state_reg)
            ADCU_IDLE: begin
                // Software or trigger edge starts
                if (wr_start_one || trig_start) begin
                    state_next = ADCU_CONV;
                    run_fast_next = conv_period_sel_reg;
                    cnt_next = 6'h00;
                    step_next = 3'h0;
                    mask_next = SAR_FIRST_BIT;
                    sar_next = SAR_FIRST_BIT;
                end
            end
            ADCU_CONV: begin
                if (wr_start_zero) begin
                    state_next = ADCU_IDLE;
                end else if (cnt_reg == conv_last) begin
                    state_next = ADCU_IDLE;
                    result_next = sar_reg;
                    done_evt = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 6'h01;
                    if (mask_reg != 8'h00) begin
                        if (step_reg == trial_last) begin
                            // Keep or drop the trial bit, try the next
                            step_next = 3'h0;
                            sar_next = (cmp_level ? sar_reg : (sar_reg & ~mask_reg))
                                | (mask_reg >> 1);
                            mask_next = mask_reg >> 1;
                        end else begin
                            step_next = step_reg + 3'h1;
                        end
                    end
                end
            end
            default: begin
                state_next = ADCU_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers, interrupts and read data
    // ****************************************
    always_comb begin
        conv_period_sel_next = conv_period_sel_reg;
        ext_trigger_enable_next = ext_trigger_enable_reg;
        chan_sel_next = chan_sel_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_in && (addr_in == ADDR_MODE_CFG)) begin
            conv_period_sel_next = wdata_in[CFG_PERIOD_BIT];
            ext_trigger_enable_next = wdata_in[CFG_TRIG_BIT];
            chan_sel_next = wdata_in[3:0];
        end
        if (wr_in && (addr_in == ADDR_IRQ_MASK)) begin
            irq_mask_next = wdata_in[1:0];
        end
        // Write one clears; a same-cycle event still sets
        if (wr_in && (addr_in == ADDR_IRQ_STATUS)) begin
            irq_stat_next = irq_stat_next & ~wdata_in[1:0];
        end
        irq_stat_next[IRQ_DONE_BIT] = irq_stat_next[IRQ_DONE_BIT] | done_evt;
        irq_stat_next[IRQ_TRIG_BIT] = irq_stat_next[IRQ_TRIG_BIT]
            | (trig_start && (state_reg == ADCU_IDLE));
        irq_next = |(irq_stat_next & irq_mask_next);
        // Channel decode toward the analog multiplexer
        chan_idx_next = {chan_sel_next[3], chan_sel_next[1:0]};
        chan_en_next = (chan_sel_next[3:2] == CHAN_LOW_GROUP)
            || (chan_sel_next[3:2] == CHAN_HIGH_GROUP);
        rdata_next = 8'h00;
        if (rd_in) begin
            case (addr_in)
                ADDR_MODE_CFG: rdata_next = CFG_FIXED_ONES
                    | {conv_period_sel_reg, ext_trigger_enable_reg, 2'h0, chan_sel_reg};
                ADDR_RESULT: rdata_next = result_reg;
                ADDR_START: rdata_next = START_FIXED_ONES
                    | {(state_reg == ADCU_CONV), 7'h00};
                ADDR_IRQ_STATUS: rdata_next = {6'h00, irq_stat_reg};
                ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ADCU_IDLE;
            conv_period_sel_reg <= 1'b0;
            ext_trigger_enable_reg <= 1'b0;
            chan_sel_reg <= CHAN_RESET;
            run_fast_reg <= 1'b0;
            cnt_reg <= 6'h00;
            step_reg <= 3'h0;
            mask_reg <= 8'h00;
            sar_reg <= 8'h00;
            result_reg <= 8'h00;
            irq_stat_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
            chan_idx_reg <= 3'h0;
            chan_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            conv_period_sel_reg <= conv_period_sel_next;
            ext_trigger_enable_reg <= ext_trigger_enable_next;
            chan_sel_reg <= chan_sel_next;
            run_fast_reg <= run_fast_next;
            cnt_reg <= cnt_next;
            step_reg <= step_next;
            mask_reg <= mask_next;
            sar_reg <= sar_next;
            result_reg <= result_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
            chan_idx_reg <= chan_idx_next;
            chan_en_reg <= chan_en_next;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_out = rdata_reg;
    assign irq_out = irq_reg;
    assign dac_code_out = sar_reg;
    assign chan_idx_out = chan_idx_reg;
    assign chan_en_out = chan_en_reg;
    assign conv_busy_out = state_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Age of the running conversion
    logic [6:0] age_reg;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            age_reg <= 7'h00;
        end else begin
            age_reg <= (state_next == ADCU_CONV && state_reg == ADCU_IDLE) ? 7'h01
                : ((state_reg == ADCU_CONV) ? age_reg + 7'h01 : 7'h00);
        end
    end

    trig_ignored_a: assert property (
        (state_reg == ADCU_IDLE) && !ext_trigger_enable_reg && !wr_start_one
        |=> state_reg == ADCU_IDLE)
        else $error("trigger started a conversion while disabled");

    trig_starts_a: assert property (
        (state_reg == ADCU_IDLE) && ext_trigger_enable_reg && trig_edge
        |=> (state_reg == ADCU_CONV) && (cnt_reg == 6'h00))
        else $error("enabled trigger edge did not start");

    chan_map_a: assert property (
        wr_in && (addr_in == ADDR_MODE_CFG) && (wdata_in[3:2] == 2'h3)
        |=> !chan_en_out)
        else $error("reserved channel code enabled the multiplexer");

    period_len_a: assert property (
        done_evt
        |-> age_reg == (run_fast_reg ? 7'(CONV_CYCLES_FAST) : 7'(CONV_CYCLES_SLOW)))
        else $error("conversion period length wrong");

    flag_read_a: assert property (
        rd_in && (addr_in == ADDR_START)
        |=> rdata_out[START_FLAG_BIT] == $past(conv_busy_out))
        else $error("start flag read does not follow conversion state");

    start_stop_a: assert property (
        wr_start_zero && !trig_start
        |=> !conv_busy_out ##1 (!conv_busy_out || $past(wr_start_one || trig_start)))
        else $error("stop write did not end the conversion");

    result_load_a: assert property (
        done_evt |=> (result_reg == $past(sar_reg)) && ($past(mask_reg) == 8'h00))
        else $error("result not loaded at conversion end");

    auto_clear_a: assert property (
        (state_reg == ADCU_CONV) && (cnt_reg == conv_last) && !wr_start
        |=> !conv_busy_out ##0 irq_stat_reg[IRQ_DONE_BIT])
        else $error("flag not cleared at conversion end");

    soft_conv_c: cover property (wr_start_one ##[1:70] done_evt);
    trig_conv_c: cover property (trig_start && !conv_busy_out ##[1:70] done_evt);
    stop_conv_c: cover property (conv_busy_out && wr_start_zero);
    fast_conv_c: cover property (done_evt && run_fast_reg);

endmodule
`default_nettype wire

// ---- testbench/adcu_analog_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcu_analog_model #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic [7:0] dac_code_in,
    input wire logic [2:0] chan_idx_in,
    input wire logic chan_en_in,
    input wire logic [7:0][7:0] level_in,
    output logic cmp_out
);
    // ****************************************
    // Comparator of the selected input
    // ****************************************
    logic [7:0] level;
    // Inputs 0 to 3 are absent on the small variant and read as ground
    always_comb begin
        level = level_in[chan_idx_in];
        if (SMALL_VARIANT && !chan_idx_in[2]) begin
            level = 8'h00;
        end
    end
    // Disabled multiplexer leaves the comparator low
    assign cmp_out = chan_en_in && (level >= dac_code_in);
endmodule
`default_nettype wire

// ---- testbench/test_adc_control_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_unit;
    import adcu_pkg::*;
    // ****************************************
    // Design hookup
    // ****************************************
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic ext_trigger_pin_in = 1'b0;
    logic cmp_in;
    logic [7:0] rdata_out;
    logic irq_out;
    logic [7:0] dac_code_out;
    logic [2:0] chan_idx_out;
    logic chan_en_out;
    logic conv_busy_out;
    logic [7:0][7:0] lvl = {8'hff, 8'h7e, 8'h3c, 8'ha5, 8'hc3, 8'h81, 8'h5a, 8'h00};
    logic [7:0] mask = 8'h00;
    logic [7:0] last_res = 8'h00;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    adcu_top u_dut (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .irq_out(irq_out),
        .ext_trigger_pin_in(ext_trigger_pin_in),
        .cmp_in(cmp_in),
        .dac_code_out(dac_code_out),
        .chan_idx_out(chan_idx_out),
        .chan_en_out(chan_en_out),
        .conv_busy_out(conv_busy_out)
    );

    adcu_analog_model u_model (
        .dac_code_in(dac_code_out),
        .chan_idx_in(chan_idx_out),
        .chan_en_in(chan_en_out),
        .level_in(lvl),
        .cmp_out(cmp_in)
    );

    // ****************************************
    // Clock and hang guard
    // ****************************************
    always #2 sys_clk_in = ~sys_clk_in;

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, e);
    endtask

    // One full conversion, started by software or by a pin edge
    task conv(input logic [7:0] cfg, input bit trig, input logic [7:0] st);
        logic [3:0] c;
        logic en;
        logic [7:0] res;
        c = cfg[3:0];
        en = (c[3:2] == 2'h1) || (c[3:2] == 2'h2);
        res = en ? lvl[{c[3], c[1:0]}] : 8'h00;
        wr(ADDR_MODE_CFG, cfg);
        rd(ADDR_MODE_CFG, cfg | 8'h30);
        if (trig) begin
            @(posedge sys_clk_in);
            ext_trigger_pin_in <= ~ext_trigger_pin_in;
        end else begin
            wr(ADDR_START, 8'h80);
        end
        #1;
        n = 0;
        while (conv_busy_out !== 1'b1 && n < 8) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk({7'h00, conv_busy_out}, 8'h01);
        chk(dac_code_out, SAR_FIRST_BIT);
        chk({4'h0, chan_en_out, chan_idx_out}, {4'h0, en, c[3], c[1:0]});
        n = 0;
        while (conv_busy_out === 1'b1 && n < 100) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk(8'(n), cfg[7] ? 8'(CONV_CYCLES_FAST) : 8'(CONV_CYCLES_SLOW));
        chk(dac_code_out, res);
        rd(ADDR_START, 8'h7f);
        rd(ADDR_RESULT, res);
        rd(ADDR_IRQ_STATUS, st);
        chk({7'h00, irq_out}, {7'h00, |(st & mask)});
        wr(ADDR_IRQ_STATUS, st);
        @(posedge sys_clk_in);
        #1;
        chk({7'h00, irq_out}, 8'h00);
        last_res = res;
    endtask

    task results;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // Reset values, unmapped place
        rd(ADDR_MODE_CFG, 8'h30);
        rd(ADDR_START, 8'h7f);
        rd(ADDR_IRQ_STATUS, 8'h00);
        rd(ADDR_IRQ_MASK, 8'h00);
        wr(8'hc9, 8'hff);
        rd(8'hc9, 8'h00);
        mask = 8'h03;
        wr(ADDR_IRQ_MASK, mask);
        rd(ADDR_IRQ_MASK, 8'h03);
        // Every channel code, fast period
        for (int c = 0; c < 16; c++) begin
            conv(8'h80 | 8'(c), 1'b0, 8'h01);
        end
        // Slow period for the longer conversion time
        conv(8'h09, 1'b0, 8'h01);
        // Result register ignores writes
        wr(ADDR_RESULT, 8'h00);
        rd(ADDR_RESULT, last_res);
        // Stop in mid-conversion
        wr(ADDR_START, 8'h80);
        rd(ADDR_START, 8'hff);
        wr(ADDR_START, 8'h00);
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk({7'h00, conv_busy_out}, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h00);
        rd(ADDR_RESULT, last_res);
        // Pin edges ignored while the trigger is off
        wr(ADDR_MODE_CFG, 8'h85);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk_in);
            ext_trigger_pin_in <= ~ext_trigger_pin_in;
            repeat (8) @(posedge sys_clk_in);
            #1;
            chk({7'h00, conv_busy_out}, 8'h00);
        end
        rd(ADDR_START, 8'h7f);
        rd(ADDR_IRQ_STATUS, 8'h00);
        // Rising then falling pin edge
        conv(8'hc5, 1'b1, 8'h03);
        conv(8'hca, 1'b1, 8'h03);
        // Trigger event alone unmasked
        mask = 8'h02;
        wr(ADDR_IRQ_MASK, mask);
        conv(8'h8b, 1'b0, 8'h01);
        results();
    end
endmodule
`default_nettype wire
